// ### rtl/ubp_fifo.sv
`timescale 1ns/100ps
module ubp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire  logic             clock,
  input  wire  logic             reset,
  input  wire  logic             in_valid,
  output logic                   in_ready,
  input  wire  logic [WIDTH-1:0] in_data,
  output logic                   out_valid,
  input  wire  logic             out_ready,
  output logic [WIDTH-1:0]       out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : ubp_fifo

// ### rtl/ubp_pkg.sv
// How it works
// - Enable bit 0 set runs the port; clear releases the pins.
// - All bit rates are divided down from the core clock.
// - Control bit 4 set divides the selected rate by eight.
// - Bits 3..1 pick 115.2K down to 7.2K baud, eighth with prescaler.
// - Status is read-only: bit 1 receive-full, bit 0 transmit-full, rest zero.
// - Receive-full sets on a received byte, clears on a data read.
// - With the serial interrupt enabled a full receive buffer raises interrupt 5.
// - Transmit-full sets on a data write, clears once shifted out.
// - With the serial interrupt enabled an empty transmitter raises interrupt 4.
// - Writing the data low byte queues it in the transmit buffer; sending starts once the shifter is idle.
// - Data read returns the last received byte, upper byte zero.
package ubp_pkg;

  localparam int unsigned CORE_CLK_HZ     = 20_000_000;
  localparam int unsigned OVERSAMPLE      = 16;
  localparam int unsigned PRESCALE_SHIFT  = 3;
  localparam int unsigned TX_FIFO_DEPTH   = 8;
  localparam int unsigned BYTE_WIDTH      = 8;
  localparam int unsigned ADDR_WIDTH      = 18;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CONTROL     = 16'hC0E0;
  localparam logic [15:0] IDX_STATUS      = 16'hC0E2;
  localparam logic [15:0] IDX_DATA        = 16'hC0E4;

  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_BAUD_LSB   = 1;
  localparam int unsigned CTRL_PRESCALE_BIT = 4;
  localparam int unsigned STAT_TX_FULL_BIT = 0;
  localparam int unsigned STAT_RX_FULL_BIT = 1;

  localparam logic        CTRL_ENABLE_RST   = 1'h1;
  localparam logic [2:0]  CTRL_BAUD_RST     = 3'h3;
  localparam logic        CTRL_PRESCALE_RST = 1'h0;

  localparam int unsigned BAUD_TABLE [8] = '{115_200, 57_600, 38_400, 28_800,
                                             19_200, 14_400, 9_600, 7_200};

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b10,
    ST_STOP  = 2'b11
  } ubp_state_t;

endpackage : ubp_pkg

// ### rtl/ubp_top.sv
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
module ubp_top
  import ubp_pkg::*;
#(
  parameter int unsigned CLK_HZ     = CORE_CLK_HZ,
  parameter int unsigned FIFO_DEPTH = TX_FIFO_DEPTH
) (
  input  wire  logic                  clock,
  input  wire  logic                  reset,
  input  wire  logic [ADDR_WIDTH-1:0] avs_address,
  input  wire  logic                  avs_read,
  input  wire  logic                  avs_write,
  input  wire  logic [31:0]           avs_writedata,
  input  wire  logic [3:0]            avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  wire  logic                  serial_int_enable,
  input  wire  logic                  general_pin_six_in,
  output logic                        general_pin_seven_out,
  output logic                        general_pin_seven_oe,
  output logic                        irq_rx_full,
  output logic                        irq_tx_empty
);

  localparam int unsigned ACC_W = 26;

  // Bus decode
  logic [15:0]            reg_index;
  logic                   hit_control;
  logic                   hit_status;
  logic                   hit_data;
  logic                   write_go;
  logic                   read_go;
  logic                   data_push;
  logic                   stall_write;

  // Control register
  logic                   ctrl_enable;
  logic [2:0]             ctrl_baud;
  logic                   divide_by_eight_enable;

  // Rate generator
  logic [ACC_W-1:0]       rate_acc;
  logic [ACC_W-1:0]       rate_step;
  logic [ACC_W-1:0]       rate_sum;
  logic                   sample_tick;

  // Transmit path
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;
  logic [BYTE_WIDTH-1:0]  fifo_out_data;
  ubp_state_t             tx_state;
  logic [3:0]             tx_sub;
  logic [2:0]             tx_count;
  logic [BYTE_WIDTH-1:0]  tx_shift;
  logic                   tx_full;
  logic                   next_tx_full;

  // Receive path
  ubp_state_t             rx_state;
  logic [3:0]             rx_sub;
  logic [2:0]             rx_count;
  logic [BYTE_WIDTH-1:0]  rx_shift;
  logic [BYTE_WIDTH-1:0]  rx_buffer;
  logic                   rx_full;
  logic                   rx_set;
  logic                   next_rx_full;

  assign reg_index   = avs_address[ADDR_WIDTH-1:2];
  assign hit_control = (reg_index == IDX_CONTROL);
  assign hit_status  = (reg_index == IDX_STATUS);
  assign hit_data    = (reg_index == IDX_DATA);
  assign write_go    = avs_write && !avs_waitrequest;
  assign read_go     = avs_read && !avs_waitrequest;
  assign data_push   = write_go && hit_data && avs_byteenable[0];
  // A data write with the buffer full waits on the bus instead of being dropped
  assign stall_write = hit_data && avs_byteenable[0] && !fifo_in_ready;

  // One wait cycle per access, longer for a data write while the transmit buffer is full
  always_ff @(posedge clock) begin
    if (reset) begin
      avs_waitrequest <= 1'h1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'h1;
    end else if (avs_read || (avs_write && !stall_write)) begin
      avs_waitrequest <= 1'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= 32'h0;
      if (hit_control) begin
        avs_readdata[CTRL_ENABLE_BIT]                   <= ctrl_enable;
        avs_readdata[CTRL_BAUD_LSB +: 3]                <= ctrl_baud;
        avs_readdata[CTRL_PRESCALE_BIT]                 <= divide_by_eight_enable;
      end else if (hit_status) begin
        avs_readdata[STAT_RX_FULL_BIT]                  <= rx_full;
        avs_readdata[STAT_TX_FULL_BIT]                  <= tx_full;
      end else if (hit_data) begin
        avs_readdata[BYTE_WIDTH-1:0]                    <= rx_buffer;
      end
    end
  end

  // Reserved bits of a write are simply not stored
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_enable            <= CTRL_ENABLE_RST;
      ctrl_baud              <= CTRL_BAUD_RST;
      divide_by_eight_enable <= CTRL_PRESCALE_RST;
    end else if (write_go && hit_control && avs_byteenable[0]) begin
      ctrl_enable            <= avs_writedata[CTRL_ENABLE_BIT];
      ctrl_baud              <= avs_writedata[CTRL_BAUD_LSB +: 3];
      divide_by_eight_enable <= avs_writedata[CTRL_PRESCALE_BIT];
    end
  end

  // Fractional divider: exact oversample rate from any core clock that fits the 26-bit accumulator
  assign rate_step = divide_by_eight_enable
                     ? ACC_W'((BAUD_TABLE[ctrl_baud] * OVERSAMPLE) >> PRESCALE_SHIFT)
                     : ACC_W'(BAUD_TABLE[ctrl_baud] * OVERSAMPLE);
  assign rate_sum  = rate_acc + rate_step;

  always_ff @(posedge clock) begin
    if (reset || !ctrl_enable) begin
      rate_acc    <= '0;
      sample_tick <= 1'h0;
    end else if (rate_sum >= ACC_W'(CLK_HZ)) begin
      rate_acc    <= rate_sum - ACC_W'(CLK_HZ);
      sample_tick <= 1'h1;
    end else begin
      rate_acc    <= rate_sum;
      sample_tick <= 1'h0;
    end
  end

  ubp_fifo #(
    .WIDTH (BYTE_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (data_push),
    .in_ready  (fifo_in_ready),
    .in_data   (avs_writedata[BYTE_WIDTH-1:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Shifter only takes a byte when idle and enabled
  assign fifo_out_ready = ctrl_enable && (tx_state == ST_IDLE);

  always_ff @(posedge clock) begin
    if (reset || !ctrl_enable) begin
      tx_state              <= ST_IDLE;
      tx_sub                <= 4'h0;
      tx_count              <= 3'h0;
      tx_shift              <= 8'h0;
      general_pin_seven_out <= 1'h1;
    end else begin
      unique case (tx_state)
        ST_IDLE: begin
          general_pin_seven_out <= 1'h1;
          if (fifo_out_valid) begin
            tx_shift              <= fifo_out_data;
            tx_sub                <= 4'h0;
            tx_count              <= 3'h0;
            tx_state              <= ST_START;
            general_pin_seven_out <= 1'h0;
          end
        end
        ST_START: begin
          if (sample_tick) begin
            tx_sub <= tx_sub + 1'b1;
            if (tx_sub == 4'hF) begin
              tx_state              <= ST_DATA;
              general_pin_seven_out <= tx_shift[0];
            end
          end
        end
        ST_DATA: begin
          if (sample_tick) begin
            tx_sub <= tx_sub + 1'b1;
            if (tx_sub == 4'hF) begin
              tx_shift <= {1'b0, tx_shift[BYTE_WIDTH-1:1]};
              tx_count <= tx_count + 1'b1;
              if (tx_count == 3'h7) begin
                tx_state              <= ST_STOP;
                general_pin_seven_out <= 1'h1;
              end else begin
                general_pin_seven_out <= tx_shift[1];
              end
            end
          end
        end
        ST_STOP: begin
          if (sample_tick) begin
            tx_sub <= tx_sub + 1'b1;
            if (tx_sub == 4'hF) begin
              tx_state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // A write sets the flag in the same edge it lands, whatever else happens
  assign next_tx_full = data_push || fifo_out_valid || (tx_state != ST_IDLE);

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_full      <= 1'h0;
      irq_tx_empty <= 1'h0;
    end else begin
      tx_full      <= next_tx_full;
      irq_tx_empty <= serial_int_enable && !next_tx_full;
    end
  end

  // Receiver samples mid-bit; a false start is dropped at half a bit
  always_ff @(posedge clock) begin
    if (reset || !ctrl_enable) begin
      rx_state  <= ST_IDLE;
      rx_sub    <= 4'h0;
      rx_count  <= 3'h0;
      rx_shift  <= 8'h0;
      rx_buffer <= 8'h0;
      rx_set    <= 1'h0;
    end else begin
      rx_set <= 1'h0;
      unique case (rx_state)
        ST_IDLE: begin
          rx_sub <= 4'h0;
          if (!general_pin_six_in) begin
            rx_state <= ST_START;
          end
        end
        ST_START: begin
          if (sample_tick) begin
            rx_sub <= rx_sub + 1'b1;
            if (rx_sub == 4'h7) begin
              rx_sub   <= 4'h0;
              rx_count <= 3'h0;
              rx_state <= general_pin_six_in ? ST_IDLE : ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (sample_tick) begin
            rx_sub <= rx_sub + 1'b1;
            if (rx_sub == 4'hF) begin
              rx_shift <= {general_pin_six_in, rx_shift[BYTE_WIDTH-1:1]};
              rx_count <= rx_count + 1'b1;
              if (rx_count == 3'h7) begin
                rx_state <= ST_STOP;
              end
            end
          end
        end
        ST_STOP: begin
          if (sample_tick) begin
            rx_sub <= rx_sub + 1'b1;
            if (rx_sub == 4'hF) begin
              rx_state <= ST_IDLE;
              // Bad stop bit discards the byte; overrun overwrites the old one
              if (general_pin_six_in) begin
                rx_buffer <= rx_shift;
                rx_set    <= 1'h1;
              end
            end
          end
        end
      endcase
    end
  end

  // Set beats a clear arriving in the same cycle
  assign next_rx_full = rx_set || (rx_full && !(read_go && hit_data));

  always_ff @(posedge clock) begin
    if (reset) begin
      rx_full     <= 1'h0;
      irq_rx_full <= 1'h0;
    end else begin
      rx_full     <= next_rx_full;
      irq_rx_full <= serial_int_enable && next_rx_full;
    end
  end

  // Pin released to general use while disabled
  always_ff @(posedge clock) begin
    if (reset) begin
      general_pin_seven_oe <= 1'h0;
    end else begin
      general_pin_seven_oe <= ctrl_enable;
    end
  end

endmodule : ubp_top

// ### verification/tb.sv
`timescale 1ns/100ps
module tb;
  import ubp_pkg::*;
  localparam int unsigned HZ    = 3_686_400;
  localparam logic [17:0] A_CTL = 18'h30380;
  localparam logic [17:0] A_STA = 18'h30388;
  localparam logic [17:0] A_DAT = 18'h30390;
  logic        clock = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, int_en = 1'b1;
  logic [17:0] avs_address = 18'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, pin_out, pin_oe, pin_in, irq_rx, irq_tx;
  int          mismatches = 0, checks = 0;
  always #25 clock = ~clock;
  ubp_top #(.CLK_HZ(HZ)) i_ubp_top (.clock(clock), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_int_enable(int_en), .general_pin_six_in(pin_in), .general_pin_seven_out(pin_out),
    .general_pin_seven_oe(pin_oe), .irq_rx_full(irq_rx), .irq_tx_empty(irq_tx));
  ubp_remote i_ubp_remote (.clock(clock), .tx_out(pin_out), .tx_oe(pin_oe), .rx_line(pin_in));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Full transmit buffer may stall a write for a whole frame
  task bus(input logic wr, input logic [17:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, A_STA, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 30000);
  endtask : wait_idle
  task t_reset;
    bus(1'b0, A_CTL, 32'h0, q);
    chk("control reset", 32'h7, q);
    chk("pin enable", 32'h1, {31'h0, pin_oe});
    chk("line idle", 32'h1, {31'h0, pin_out});
    bus(1'b0, 18'h30394, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    bus(1'b1, A_STA, 32'h3, q);
    bus(1'b0, A_STA, 32'h0, q);
    chk("status read-only", 32'h0, q);
  endtask : t_reset
  task t_rates;
    logic ok;
    for (int r = 0; r < 9; r++) begin
      i_ubp_remote.bit_cycles = HZ / BAUD_TABLE[r % 8] * (r == 8 ? 8 : 1);
      bus(1'b1, A_CTL, {27'h0, r == 8, r[2:0], 1'b1}, q);
      // Second low run is a whole data bit, free of the start bit's tick phase
      bus(1'b1, A_DAT, 32'hFD, q);
      bus(1'b0, A_STA, 32'h0, q);
      chk("tx full set", 32'h1, q);
      wait_idle;
      chk("tx full clear", 32'h0, q);
      ok = (i_ubp_remote.lo_len - i_ubp_remote.bit_cycles) inside {[-2:2]};
      chk("bit length", 32'h1, {31'h0, ok});
    end
  endtask : t_rates
  task t_burst;
    bus(1'b1, A_CTL, 32'h1, q);
    i_ubp_remote.bit_cycles = 32;
    i_ubp_remote.got.delete();
    for (int i = 0; i < 10; i++) bus(1'b1, A_DAT, 32'hA0 + 32'(i), q);
    chk("tx irq busy", 32'h0, {31'h0, irq_tx});
    wait_idle;
    chk("tx irq idle", 32'h1, {31'h0, irq_tx});
    for (int i = 0; i < 10; i++)
      chk("sent byte", 32'hA0 + 32'(i), {24'h0, i_ubp_remote.got[i]});
  endtask : t_burst
  task t_rx;
    logic [7:0] b;
    for (int k = 0; k < 2; k++) begin
      b = k ? 8'hC3 : 8'h5A;
      int_en <= (k == 0);
      i_ubp_remote.send(b);
      bus(1'b0, A_STA, 32'h0, q);
      chk("rx full set", 32'h2, q);
      chk("rx irq", {31'h0, int_en}, {31'h0, irq_rx});
      chk("tx irq", {31'h0, int_en}, {31'h0, irq_tx});
      bus(1'b0, A_DAT, 32'h0, q);
      chk("rx data", {24'h0, b}, q);
      bus(1'b0, A_STA, 32'h0, q);
      chk("rx full clear", 32'h0, q);
      chk("rx irq clear", 32'h0, {31'h0, irq_rx});
    end
  endtask : t_rx
  task t_disable;
    bus(1'b1, A_CTL, 32'h0, q);
    bus(1'b0, A_CTL, 32'h0, q);
    chk("pin released", 32'h0, {31'h0, pin_oe});
    i_ubp_remote.send(8'h11);
    bus(1'b0, A_STA, 32'h0, q);
    chk("no rx when off", 32'h0, q);
    bus(1'b1, A_CTL, 32'h1, q);
  endtask : t_disable
  task summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    t_reset;
    t_rates;
    t_burst;
    t_rx;
    t_disable;
    summarize;
  end
  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    summarize;
  end
endmodule : tb

// ### verification/ubp_remote.sv
`timescale 1ns/100ps
module ubp_remote (
  input  wire logic clock,
  input  wire logic tx_out,
  input  wire logic tx_oe,
  output logic      rx_line
);
  int         bit_cycles = 32;
  int         lo_len     = 0;
  logic [7:0] got[$];
  // Pull-up holds a released pin high
  wire logic  line = tx_oe ? tx_out : 1'b1;
  initial rx_line = 1'b1;
  always @(negedge line) begin : measure
    int n;
    n = 0;
    while (line === 1'b0) begin
      @(posedge clock);
      n++;
    end
    lo_len = n;
  end
  // Mid-bit sampling tolerates one clock of jitter
  always begin : decode
    logic [7:0] b;
    @(negedge line);
    repeat (bit_cycles / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cycles) @(posedge clock);
      b[i] = line;
    end
    repeat (bit_cycles) @(posedge clock);
    if (line === 1'b1) got.push_back(b);
  end
  task send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (bit_cycles) @(posedge clock);
    end
  endtask : send
endmodule : ubp_remote

// ### verification/ubp_top_monitor.sv
`timescale 1ns/100ps
module ubp_top_monitor
  import ubp_pkg::*;
#(
  parameter int unsigned CLK_HZ     = CORE_CLK_HZ,
  parameter int unsigned FIFO_DEPTH = TX_FIFO_DEPTH
) (
  input wire logic                  clock,
  input wire logic                  reset,
  input wire logic [ADDR_WIDTH-1:0] avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_writedata,
  input wire logic [3:0]            avs_byteenable,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic                  serial_int_enable,
  input wire logic                  general_pin_six_in,
  input wire logic                  general_pin_seven_out,
  input wire logic                  general_pin_seven_oe,
  input wire logic                  irq_rx_full,
  input wire logic                  irq_tx_empty
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire logic acc    = !avs_waitrequest;
  wire logic rd_sta = avs_read && acc && avs_address[17:2] == IDX_STATUS;
  wire logic rd_dat = avs_read && acc && avs_address[17:2] == IDX_DATA;
  wire logic wr_lo  = avs_write && acc && avs_byteenable[0];
  wire logic wr_ctl = wr_lo && avs_address[17:2] == IDX_CONTROL;
  wire logic wr_dat = wr_lo && avs_address[17:2] == IDX_DATA;
  pin_release_a:
    assert property (wr_ctl && !avs_writedata[0] |=> ##[0:2] !general_pin_seven_oe)
    else $error("pin not released after disable");
  idle_high_a:
    assert property (!general_pin_seven_oe |-> general_pin_seven_out)
    else $error("released line not high");
  start_len_a:
    assert property ($fell(general_pin_seven_out) |-> !general_pin_seven_out [*8])
    else $error("start bit too short");
  tx_start_a:
    assert property (wr_dat && general_pin_seven_oe && irq_tx_empty
                     |-> ##[1:5] !general_pin_seven_out)
    else $error("data write did not start a frame");
  tx_busy_a:
    assert property (wr_dat && serial_int_enable |=> ##[1:2] !irq_tx_empty)
    else $error("transmit empty kept after write");
  rx_mask_a:
    assert property (!serial_int_enable |=> !irq_rx_full)
    else $error("receive irq while masked");
  tx_mask_a:
    assert property (!serial_int_enable |=> !irq_tx_empty)
    else $error("transmit irq while masked");
  rx_clear_a:
    assert property (rd_dat |=> ##1 !irq_rx_full)
    else $error("receive full kept after data read");
  status_zero_a:
    assert property (rd_sta |-> avs_readdata[31:2] == 30'h0)
    else $error("status reserved bits set");
  data_upper_a:
    assert property (rd_dat |-> avs_readdata[31:8] == 24'h0)
    else $error("data upper bits set");
endmodule : ubp_top_monitor

bind ubp_top ubp_top_monitor #(.CLK_HZ(CLK_HZ), .FIFO_DEPTH(FIFO_DEPTH)) i_ubp_top_monitor (
  .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .serial_int_enable(serial_int_enable), .general_pin_six_in(general_pin_six_in),
  .general_pin_seven_out(general_pin_seven_out), .general_pin_seven_oe(general_pin_seven_oe),
  .irq_rx_full(irq_rx_full), .irq_tx_empty(irq_tx_empty));
